// *** bank0_sfr_map_bench.sv ***
`default_nettype none
module bank0_sfr_map_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        branch_strobe = 1'b0;
  logic        periph_we = 1'b0;
  logic [4:0]  periph_idx = 5'h00;
  logic [7:0]  periph_wdata = 8'h00;
  logic [7:0]  pin [10] = '{default: 8'h00};
  logic [7:0]  d [32];
  logic [7:0]  q;
  logic [31:0] lfsr = 32'h4072;
  int          cyc = 0;
  int          num_errors = 0;
  int          checks = 0;
  wire logic        psel, penable, pwrite, pready, pslverr;
  wire logic [11:0] paddr;
  wire logic [31:0] pwdata, prdata;
  wire logic [3:0]  pstrb;
  wire logic [4:0]  pc_upper;
  wire logic [7:0]  port_a_latch, port_b_latch, port_c_latch, port_d_latch, port_e_latch;
  wire logic [7:0]  pc_low_byte, core_status_flags, indirect_pointer, interrupt_control;
  wire logic [7:0]  port_a_in = pin[5], port_b_in = pin[6], port_c_in = pin[7];
  wire logic [7:0]  port_d_in = pin[8], port_e_in = pin[9];
  bsfr_bank0 bsfr_bank0_inst (.*);
  bsfr_cpu_model bsfr_cpu_model_inst (.*);
  initial begin
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], ^(lfsr & 32'h80200003)};
    return lfsr[7:0];
  endfunction
  function automatic logic [7:0] wm(input int i);
    case (i)
      3: return 8'he7;
      5, 16, 23, 29: return 8'h3f;
      9: return 8'h07;
      10: return 8'h1f;
      13: return 8'h01;
      18: return 8'h7f;
      24: return 8'hf1;
      26, 30: return 8'h00;
      31: return 8'hfd;
      default: return 8'hff;
    endcase
  endfunction
  // Ports read pins, status keeps its fixed bits
  function automatic logic [7:0] ex(input int i, input logic [7:0] v);
    return (((i >= 5 && i <= 9) ? pin[i] : v) & wm(i)) | (i == 3 ? 8'h18 : 8'h00);
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input int a, input logic [7:0] v);
    bsfr_cpu_model_inst.xfer(1'b1, 12'(a), v, 1'b1, q);
  endtask
  task automatic rd(input int a);
    bsfr_cpu_model_inst.xfer(1'b0, 12'(a), rnd(), 1'b1, q);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    @(posedge pclk);
    for (int i = 5; i <= 9; i++) pin[i] <= rnd();
    repeat (7) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 32; i++) begin
      rd(i * 4);
      chk(q, ex(i, 8'h00));
    end
    $display("test reset done");
    for (int i = 1; i < 32; i++) begin
      d[i] = rnd();
      wr(i * 4, d[i]);
    end
    for (int i = 1; i < 32; i++) begin
      rd(i * 4);
      chk(q, ex(i, d[i]));
    end
    chk(port_b_latch, d[6]);
    chk(port_e_latch, d[9] & 8'h07);
    chk(pc_low_byte, d[2]);
    chk(interrupt_control, d[11]);
    chk(core_status_flags, ex(3, d[3]));
    chk({7'h00, pslverr}, 8'h00);
    $display("test readback done");
    wr(12, 8'h00);
    wr(16, 8'h0c);
    wr(0, d[5]);
    rd(48);
    chk(q, d[5]);
    wr(16, 8'h07);
    rd(0);
    chk(q, pin[7]);
    $display("test indirect done");
    wr(12'h610, d[6]);
    rd(16);
    chk(q, d[6]);
    rd(12'h214);
    chk(q, 8'h00);
    rd(12'h080);
    chk(q, 8'h00);
    bsfr_cpu_model_inst.xfer(1'b1, 12'h004, ~d[1], 1'b0, q);
    rd(4);
    chk(q, d[1]);
    $display("test decode done");
    wr(40, ~d[10]);
    chk({3'h0, pc_upper}, 8'h00);
    branch_strobe <= 1'b1;
    @(posedge pclk);
    branch_strobe <= 1'b0;
    @(posedge pclk);
    chk({3'h0, pc_upper}, ~d[10] & 8'h1f);
    $display("test branch done");
    periph_idx <= 5'h1a;
    periph_wdata <= d[26];
    periph_we <= 1'b1;
    @(posedge pclk);
    periph_we <= 1'b0;
    rd(104);
    chk(q, d[26]);
    $display("test peripheral done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** bsfr_bank0.sv ***
// Behaviour
// - Registers kept in static storage cells
// - Port A writes latch, reads pins
// - Port C writes latch, reads pins
// - Port D writes latch, reads pins
// - Core registers decode in every bank
// - Latch copied to PC upper on branch
// - Unimplemented bits ignore writes, read zero
// - Small package: port D/E absent, zero
`include "bsfr_defs.svh"
`default_nettype none
module bsfr_bank0
  import bsfr_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`BSFR_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Port pin levels
  input  wire logic [7:0]              port_a_in,
  input  wire logic [7:0]              port_b_in,
  input  wire logic [7:0]              port_c_in,
  input  wire logic [7:0]              port_d_in,
  input  wire logic [7:0]              port_e_in,
  // Port output latches
  output logic      [7:0]              port_a_latch,
  output logic      [7:0]              port_b_latch,
  output logic      [7:0]              port_c_latch,
  output logic      [7:0]              port_d_latch,
  output logic      [7:0]              port_e_latch,
  // Core view
  input  wire logic                    branch_strobe,
  output logic      [7:0]              pc_low_byte,
  output logic      [4:0]              pc_upper,
  output logic      [7:0]              core_status_flags,
  output logic      [7:0]              indirect_pointer,
  output logic      [7:0]              interrupt_control,
  // Peripheral update path
  input  wire logic                    periph_we,
  input  wire logic [4:0]              periph_idx,
  input  wire logic [7:0]              periph_wdata
);

  // Implemented bits of each location
  function automatic bsfr_byte_t impl_mask(input logic [4:0] idx);
    bsfr_byte_t m;
    m = `BSFR_MASK_FULL;
    case (idx)
      `BSFR_IDX_INDIRECT: m = `BSFR_MASK_NONE;
      `BSFR_IDX_PORT_A:   m = `BSFR_MASK_PORT_A;
      `BSFR_IDX_PORT_D:   m = SMALL_PACKAGE ? `BSFR_MASK_NONE : `BSFR_MASK_FULL;
      `BSFR_IDX_PORT_E:   m = SMALL_PACKAGE ? `BSFR_MASK_NONE : `BSFR_MASK_PORT_E;
      `BSFR_IDX_PC_LATCH: m = `BSFR_MASK_PC_LATCH;
      `BSFR_IDX_PFLAG2:   m = `BSFR_MASK_PFLAG2;
      `BSFR_IDX_T1CTL:    m = `BSFR_MASK_CTL6;
      `BSFR_IDX_T2CTL:    m = `BSFR_MASK_T2CTL;
      `BSFR_IDX_CCP1CTL:  m = `BSFR_MASK_CTL6;
      `BSFR_IDX_RXSTAT:   m = `BSFR_MASK_RXSTAT;
      `BSFR_IDX_CCP2CTL:  m = `BSFR_MASK_CTL6;
      `BSFR_IDX_ADCTL:    m = `BSFR_MASK_ADCTL;
      default:            m = `BSFR_MASK_FULL;
    endcase
    return m;
  endfunction

  // Bits software may write; flags owned by hardware are left out
  function automatic bsfr_byte_t sw_mask(input logic [4:0] idx);
    bsfr_byte_t m;
    m = impl_mask(idx);
    case (idx)
      `BSFR_IDX_STATUS: m = m & ~`BSFR_RO_STATUS;
      `BSFR_IDX_RXSTAT: m = m & ~`BSFR_RO_RXSTAT;
      `BSFR_IDX_RXDATA: m = `BSFR_MASK_NONE;
      `BSFR_IDX_CONVERTER_RESULT:  m = `BSFR_MASK_NONE;
      default:          m = m;
    endcase
    return m;
  endfunction

  // Registers seen from every bank
  function automatic logic is_common(input logic [4:0] idx);
    logic c;
    c = 1'b0;
    case (idx)
      `BSFR_IDX_INDIRECT: c = 1'b1;
      `BSFR_IDX_PC_LOW:   c = 1'b1;
      `BSFR_IDX_STATUS:   c = 1'b1;
      `BSFR_IDX_POINTER:  c = 1'b1;
      `BSFR_IDX_PC_LATCH: c = 1'b1;
      `BSFR_IDX_INTCTL:   c = 1'b1;
      default:            c = 1'b0;
    endcase
    return c;
  endfunction

  // Bank and offset to a location of this map
  function automatic bsfr_dec_s decode(input logic [1:0] bank, input logic [6:0] off);
    bsfr_dec_s d;
    d.idx = off[4:0];
    d.hit = 1'b0;
    if (off < `BSFR_OFF_LIMIT) begin
      d.hit = (bank == `BSFR_BANK0) || is_common(off[4:0]);
    end
    return d;
  endfunction

  bsfr_state_s st;
  bsfr_state_s next_st;

  logic [8:0]  bus_index;
  bsfr_dec_s   bus_dec;
  bsfr_dec_s   ind_dec;
  bsfr_dec_s   tgt_dec;
  logic        bus_setup;
  logic        bus_access;
  bsfr_byte_t  rd_byte;
  bsfr_byte_t  wr_mask;
  bsfr_byte_t  cur_status;
  bsfr_byte_t  cur_pointer;

  assign bus_index   = paddr[10:2];
  assign bus_setup   = psel && !penable;
  assign bus_access  = psel && penable && pready;
  assign cur_status  = st.mem[`BSFR_IDX_STATUS];
  assign cur_pointer = st.mem[`BSFR_IDX_POINTER];

  // Zero wait states; read data is captured during the setup cycle
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    bus_dec = decode(bus_index[8:7], bus_index[6:0]);
    ind_dec = decode({cur_status[`BSFR_STATUS_IRP], cur_pointer[`BSFR_PTR_BANK_BIT]},
                     cur_pointer[6:0]);
    tgt_dec = bus_dec;
    if (bus_dec.hit && bus_dec.idx == `BSFR_IDX_INDIRECT) begin
      tgt_dec = ind_dec;
      // Pointing back at offset zero would loop; treat it as empty
      if (ind_dec.idx == `BSFR_IDX_INDIRECT) begin
        tgt_dec.hit = 1'b0;
      end
    end
  end

  // Read value of the resolved location
  always_comb begin
    rd_byte = `BSFR_MASK_NONE;
    if (tgt_dec.hit) begin
      case (tgt_dec.idx)
        `BSFR_IDX_PORT_A: rd_byte = port_a_in;
        `BSFR_IDX_PORT_B: rd_byte = port_b_in;
        `BSFR_IDX_PORT_C: rd_byte = port_c_in;
        `BSFR_IDX_PORT_D: rd_byte = port_d_in;
        `BSFR_IDX_PORT_E: rd_byte = port_e_in;
        default:          rd_byte = st.mem[tgt_dec.idx];
      endcase
      rd_byte = rd_byte & impl_mask(tgt_dec.idx);
    end
  end

  always_comb begin
    next_st = st;
    wr_mask = sw_mask(tgt_dec.idx);
    if (bus_setup && !pwrite) begin
      next_st.rdata = {24'h000000, rd_byte};
    end
    if (bus_access && pwrite && pstrb[0] && tgt_dec.hit) begin
      next_st.mem[tgt_dec.idx] = (st.mem[tgt_dec.idx] & ~wr_mask)
                               | (pwdata[7:0] & wr_mask);
      // A computed jump takes the upper bits along with the low byte
      if (tgt_dec.idx == `BSFR_IDX_PC_LOW) begin
        next_st.pc_upper = st.mem[`BSFR_IDX_PC_LATCH][4:0];
      end
    end
    if (branch_strobe) begin
      next_st.pc_upper = st.mem[`BSFR_IDX_PC_LATCH][4:0];
    end
    // Hardware update lands last so an event in the write cycle is kept
    if (periph_we) begin
      next_st.mem[periph_idx] = periph_wdata & impl_mask(periph_idx);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st                       <= '0;
      st.mem[`BSFR_IDX_STATUS] <= `BSFR_STATUS_RST;
    end else begin
      st <= next_st;
    end
  end

  // Latch outputs; absent ports drive zero
  assign port_a_latch      = st.mem[`BSFR_IDX_PORT_A] & impl_mask(`BSFR_IDX_PORT_A);
  assign port_b_latch      = st.mem[`BSFR_IDX_PORT_B];
  assign port_c_latch      = st.mem[`BSFR_IDX_PORT_C];
  assign port_d_latch      = st.mem[`BSFR_IDX_PORT_D] & impl_mask(`BSFR_IDX_PORT_D);
  assign port_e_latch      = st.mem[`BSFR_IDX_PORT_E] & impl_mask(`BSFR_IDX_PORT_E);
  assign pc_low_byte       = st.mem[`BSFR_IDX_PC_LOW];
  assign pc_upper          = st.pc_upper;
  assign core_status_flags = cur_status;
  assign indirect_pointer  = cur_pointer;
  assign interrupt_control = st.mem[`BSFR_IDX_INTCTL];
  assign prdata            = st.rdata;

endmodule
`default_nettype wire

// *** bsfr_bank0_checker.sv ***
`default_nettype none
module bsfr_bank0_checker (
  // Clock and bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  // Core and pins
  input wire logic        periph_we,
  input wire logic        branch_strobe,
  input wire logic [7:0]  port_a_in,
  input wire logic [7:0]  port_a_latch,
  input wire logic [7:0]  port_c_latch,
  input wire logic [7:0]  port_d_latch,
  input wire logic [4:0]  pc_upper,
  input wire logic [7:0]  indirect_pointer
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Peripheral writes win, so they stay out of the bus checks
  wire logic wr = psel && penable && pwrite && pstrb[0] && !periph_we;
  wire logic rd = psel && !penable && !pwrite;
  port_a_pins_wr_a: assert property (wr && paddr == 12'h014 |=>
    port_a_latch == ($past(pwdata[7:0]) & 8'h3f)) else $error("port a latch");
  port_c_pins_wr_a: assert property (wr && paddr == 12'h01c |=>
    port_c_latch == $past(pwdata[7:0])) else $error("port c latch");
  port_d_pins_wr_a: assert property (wr && paddr == 12'h020 |=>
    port_d_latch == $past(pwdata[7:0])) else $error("port d latch");
  port_a_pins_rd_a: assert property ($stable(port_a_in)[*3] ##0 (rd && paddr == 12'h014) |=>
    prdata == {24'h0, $past(port_a_in) & 8'h3f}) else $error("port a read");
  hi_zero_a: assert property (prdata[31:8] == 24'h0) else $error("upper read bits");
  unmapped_a: assert property (rd && paddr[10:9] == 2'h0 && paddr[8:7] != 2'h0 |=>
    prdata == 32'h0) else $error("unmapped read");
  ptr_bank_a: assert property (wr && paddr[8:2] == 7'h04 |=>
    indirect_pointer == $past(pwdata[7:0])) else $error("pointer mirror");
  pcu_hold_a: assert property (!branch_strobe && !(psel && pwrite) && !periph_we |=>
    $stable(pc_upper)) else $error("pc upper moved");
  cover property (wr && paddr == 12'h000);
  cover property (branch_strobe);
  cover property (rd && paddr[10:9] != 2'h0);
endmodule
bind bsfr_bank0 bsfr_bank0_checker bsfr_bank0_checker_inst (.*);
`default_nettype wire

// *** bsfr_cpu_model.sv ***
`default_nettype none
module bsfr_cpu_model (
  // Answer
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  // Request
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  output var  logic [3:0]  pstrb
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  // Held until pready is seen; idle address and data lines then show inverted junk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic s, output logic [7:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {~d, ~d, ~d, d};
    pstrb <= {3'h7, s};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~pwdata;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// *** bsfr_defs.svh ***
`ifndef BSFR_DEFS_SVH
`define BSFR_DEFS_SVH

// Location indices (byte address on the bus is four times the index)
`define BSFR_IDX_INDIRECT   5'h00
`define BSFR_IDX_TIMER_ZERO_COUNT       5'h01
`define BSFR_IDX_PC_LOW     5'h02
`define BSFR_IDX_STATUS     5'h03
`define BSFR_IDX_POINTER    5'h04
`define BSFR_IDX_PORT_A     5'h05
`define BSFR_IDX_PORT_B     5'h06
`define BSFR_IDX_PORT_C     5'h07
`define BSFR_IDX_PORT_D     5'h08
`define BSFR_IDX_PORT_E     5'h09
`define BSFR_IDX_PC_LATCH   5'h0a
`define BSFR_IDX_INTCTL     5'h0b
`define BSFR_IDX_PFLAG1     5'h0c
`define BSFR_IDX_PFLAG2     5'h0d
`define BSFR_IDX_TIMER_ONE_LOW      5'h0e
`define BSFR_IDX_TIMER_ONE_HIGH      5'h0f
`define BSFR_IDX_T1CTL      5'h10
`define BSFR_IDX_TIMER_TWO_COUNT       5'h11
`define BSFR_IDX_T2CTL      5'h12
`define BSFR_IDX_SSBUF      5'h13
`define BSFR_IDX_SSCTL      5'h14
`define BSFR_IDX_CCP1L      5'h15
`define BSFR_IDX_CCP1H      5'h16
`define BSFR_IDX_CCP1CTL    5'h17
`define BSFR_IDX_RXSTAT     5'h18
`define BSFR_IDX_TXDATA     5'h19
`define BSFR_IDX_RXDATA     5'h1a
`define BSFR_IDX_CCP2L      5'h1b
`define BSFR_IDX_CCP2H      5'h1c
`define BSFR_IDX_CCP2CTL    5'h1d
`define BSFR_IDX_CONVERTER_RESULT      5'h1e
`define BSFR_IDX_ADCTL      5'h1f

// Bus address layout
`define BSFR_ADDR_W         12
`define BSFR_OFF_LIMIT      7'h20
`define BSFR_BANK0          2'h0

// Implemented bits per location
`define BSFR_MASK_FULL      8'hff
`define BSFR_MASK_NONE      8'h00
`define BSFR_MASK_PORT_A    8'h3f
`define BSFR_MASK_PORT_E    8'h07
`define BSFR_MASK_PC_LATCH  8'h1f
`define BSFR_MASK_PFLAG2    8'h01
`define BSFR_MASK_CTL6      8'h3f
`define BSFR_MASK_T2CTL     8'h7f
`define BSFR_MASK_RXSTAT    8'hf7
`define BSFR_MASK_ADCTL     8'hfd

// Bits software cannot write
`define BSFR_RO_STATUS      8'h18
`define BSFR_RO_RXSTAT      8'h06

// Status reset value and bank select fields
`define BSFR_STATUS_RST     8'h18
`define BSFR_STATUS_IRP     7
`define BSFR_PTR_BANK_BIT   7

`endif

// *** bsfr_pkg.sv ***
`default_nettype none
package bsfr_pkg;
  typedef logic [7:0] bsfr_byte_t;
  typedef struct packed {
    logic       hit;
    logic [4:0] idx;
  } bsfr_dec_s;
  typedef struct packed {
    logic [31:0][7:0] mem;
    logic [4:0]       pc_upper;
    logic [31:0]      rdata;
  } bsfr_state_s;
endpackage
`default_nettype wire
